// ===== hw/aud_defines.vh
/*
 * Constants for the waveform RAM playback sequencer: register offsets,
 * field positions, reset values and timing counts.
 * Assumes it is included once per design file by its bare name.
 */
`ifndef AUD_DEFINES_VH
`define AUD_DEFINES_VH

// Register byte offsets on the plain register port.
`define AUD_CTRL_OFS 4'h0
`define AUD_MUX_OFS 4'h4
`define AUD_STAT_OFS 4'h8

// Control register fields.
`define AUD_CTRL_CYCLE_BIT 0
`define AUD_CTRL_RESET 1'b0

// Multiplexer register fields: select in bits 3..0, enables in 4 and 5.
`define AUD_MUX_EN_A_BIT 4
`define AUD_MUX_EN_B_BIT 5
`define AUD_MUX_RESET 6'h00

// Status register fields.
`define AUD_STAT_CYCLING_BIT 0
`define AUD_STAT_INACTIVE_BIT 1
`define AUD_STAT_FULL_BIT 2
`define AUD_STAT_CNT_LSB 16

// Playback timing: oscillator in kHz, system clock in kHz, and
// oscillator periods per RAM location.
`define AUD_OSC_KHZ 19660.8
`define AUD_SYS_KHZ 20000
`define AUD_OSC_PER_WORD 20
// Phase accumulator step and wrap, in hundredths of a hertz-kilo unit, so that
// one word tick falls every twenty oscillator periods on average.
`define AUD_ACC_STEP 24'h018000
`define AUD_ACC_WRAP 24'h1e8480

// Carrier address offset of 7.5 degrees of a 32768-location sweep.
`define AUD_CAR_OFFSET 15'h02ab

// Bi-phase multipliers for the two rates, in cycles per sweep.
`define AUD_BIPHS_DOPPLER 5'h18
`define AUD_BIPHS_CONV 5'h01
// Commutator sectors per sweep.
`define AUD_COMM_SECTORS 3'h6

`endif

// ===== hw/aud_seq.v
/*
 * Waveform RAM playback sequencer with its word FIFO.
 * Assumes a single 20 MHz clock, a synchronous active-low reset, RAM data
 * returned in the clock domain, and asynchronous strap and link pins.
 */
// The register offsets and the plain strobed port are this design's own decisions.
// Behaviour
// - Not cycling: processor bus passes to RAMs.
// - Cycling: counters drive RAM address and control.
// - Every location read once per thirtieth second.
// - Carrier DAC strobe while carrier word valid.
// - Sideband strobe and select; bytes split.
// - Carrier offset when jumper and ground-check high.
// - Inactive plus sync rising edge clears counters.
// - Doppler input picks 720 or 30 Hz.
// - Commutator lines generated only while cycling.
// - Commutator lines forwarded only when on antenna.
// - Four mux selects, two exclusive output enables.
// - Last commutator sector also on sync output, not gated off antenna.
// - Active-low system reset restarts the sequencer.
// - Six commutator switching control lines.
`timescale 1ns/1ps
`include "aud_defines.vh"

module aud_fifo #(
   parameter W = 32,
   parameter D = 16,
   parameter AW = 4
) (
   input wire sys_clk,
   input wire nrst,
   input wire flush,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem [0:D-1]; // Flip-flop storage, one entry per word.
   reg [AW-1:0] wr_ptr_reg; // Next entry to fill.
   reg [AW-1:0] rd_ptr_reg; // Next entry to drain.
   reg [AW:0] count_reg; // Number of entries held.
   wire push;
   wire pop;

   assign in_ready = (count_reg != D[AW:0]);
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Storage write; a flushed FIFO keeps stale data, which is never read.
   always @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and occupancy; flush wins over any push or pop.
   always @(posedge sys_clk) begin
      if (!nrst || flush) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

module aud_seq #(
   parameter AW = 15,
   parameter FIFO_DEPTH = 16
) (
   input wire sys_clk,
   input wire nrst,
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire [AW-1:0] proc_addr,
   input wire [15:0] proc_wdata,
   output reg [15:0] proc_rdata,
   input wire proc_car_sel,
   input wire proc_sb_sel,
   input wire proc_wr,
   input wire proc_rd,
   output reg [AW-1:0] ram_addr,
   input wire [15:0] ram_dq_in,
   output reg [15:0] ram_dq_out,
   output reg ram_dq_oe,
   output reg carrier_wave_ram_cs_n,
   output reg sideband_wave_ram_cs_n,
   output reg ram_we_n,
   output reg ram_oe_n,
   output reg [15:0] carrier_dac_data,
   output reg [7:0] sb13_dac_data,
   output reg [7:0] sb24_dac_data,
   output reg carrier_dac_write_n,
   output reg sideband_dac_write_n,
   output reg sideband_dac_select,
   input wire offset_jumper,
   input wire ground_check_pos,
   input wire ground_check_neg,
   input wire antenna_inactive,
   input wire cycle_sync_in,
   input wire doppler_config,
   output reg sine_biphase_out,
   output reg cosine_biphase_out,
   output reg [5:0] commutator_ctrl,
   output reg sync_observe,
   output reg [3:0] mux_select,
   output reg mux_a_output_enable,
   output reg mux_b_output_enable
);
   // Fetch states: issue a read, then capture the word it returns.
   localparam F_IDLE = 2'b00;
   localparam F_CAR = 2'b01;
   localparam F_SB = 2'b10;
   localparam F_PUSH = 2'b11;
   // Drain states: load DAC data, strobe low, strobe high.
   localparam D_IDLE = 2'b00;
   localparam D_LOW = 2'b01;
   localparam D_HIGH = 2'b10;

   reg ctrl_cycle_reg; // Software cycling request.
   reg [5:0] mux_reg; // Software multiplexer setting.
   reg [5:0] s1_reg; // First synchroniser stage of the six pins.
   reg [5:0] s2_reg; // Second stage; the only stage that logic reads.
   reg sync_d_reg; // Previous synchronised cycle-sync level.
   reg [23:0] acc_reg; // Oscillator phase accumulator.
   reg tick_reg; // One-cycle word tick.
   reg [AW-1:0] play_cnt_reg; // Location being played.
   reg [AW-1:0] fetch_addr_reg; // Next location to fetch.
   reg [1:0] fetch_st_reg;
   reg [1:0] drain_st_reg;
   reg [15:0] car_word_reg; // Carrier word awaiting its sideband partner.
   reg [15:0] sb_word_reg;
   wire jumper_s = s2_reg[0];
   wire gc_high = s2_reg[1] & ~s2_reg[2];
   wire inactive_s = s2_reg[3];
   wire sync_s = s2_reg[4];
   wire doppler_s = s2_reg[5];
   wire resync = inactive_s & sync_s & ~sync_d_reg;
   wire flush = ~ctrl_cycle_reg | resync;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [31:0] fifo_out_data;
   wire fifo_pop = (drain_st_reg == D_IDLE) & tick_reg & fifo_out_valid;
   wire [AW-1:0] car_addr;
   wire [AW+4:0] phase_prod;
   wire [AW+2:0] sector_prod;

   // Carrier reads take the offset when the jumper is in and the ground check is high.
   assign car_addr = fetch_addr_reg + ((jumper_s & gc_high) ? `AUD_CAR_OFFSET : 15'h0000);
   assign phase_prod = play_cnt_reg * (doppler_s ? `AUD_BIPHS_DOPPLER : `AUD_BIPHS_CONV);
   assign sector_prod = play_cnt_reg * `AUD_COMM_SECTORS;

   aud_fifo #(.W(32), .D(FIFO_DEPTH), .AW(4)) aud_fifo_i (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .flush(flush),
      .in_valid(fetch_st_reg == F_PUSH),
      .in_ready(fifo_in_ready),
      .in_data({car_word_reg, sb_word_reg}),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   // Two-flop synchronisers for the strap, ground-check, link and config pins.
   always @(posedge sys_clk) begin
      if (!nrst) begin
         s1_reg <= 6'h00;
         s2_reg <= 6'h00;
         sync_d_reg <= 1'b0;
      end else begin
         s1_reg <= {doppler_config, cycle_sync_in, antenna_inactive,
                    ground_check_neg, ground_check_pos, offset_jumper};
         s2_reg <= s1_reg;
         sync_d_reg <= sync_s;
      end
   end

   // Register port; reads answer one cycle later, unmapped reads give zero.
   always @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_cycle_reg <= `AUD_CTRL_RESET;
         mux_reg <= `AUD_MUX_RESET;
         reg_rdata <= 32'h00000000;
      end else begin
         if (reg_wr && reg_addr == `AUD_CTRL_OFS) begin
            ctrl_cycle_reg <= reg_wdata[`AUD_CTRL_CYCLE_BIT];
         end
         if (reg_wr && reg_addr == `AUD_MUX_OFS) begin
            mux_reg <= reg_wdata[5:0];
         end
         reg_rdata <= 32'h00000000;
         if (reg_rd) begin
            case (reg_addr)
               `AUD_CTRL_OFS: reg_rdata <= {31'h00000000, ctrl_cycle_reg};
               `AUD_MUX_OFS: reg_rdata <= {26'h0000000, mux_reg};
               `AUD_STAT_OFS: reg_rdata <= {1'b0, play_cnt_reg, 13'h0000, ~fifo_in_ready,
                                            inactive_s, ctrl_cycle_reg};
               default: reg_rdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Word tick: the accumulator models the 19.6608 MHz oscillator divided
   // by twenty, so ticks jitter by one system cycle but average exactly.
   always @(posedge sys_clk) begin
      if (!nrst || flush) begin
         acc_reg <= 24'h000000;
         tick_reg <= 1'b0;
      end else if (acc_reg + `AUD_ACC_STEP >= `AUD_ACC_WRAP) begin
         acc_reg <= acc_reg + `AUD_ACC_STEP - `AUD_ACC_WRAP;
         tick_reg <= 1'b1;
      end else begin
         acc_reg <= acc_reg + `AUD_ACC_STEP;
         tick_reg <= 1'b0;
      end
   end

   // Fetch engine and RAM pins; it stalls when the FIFO is full.
   always @(posedge sys_clk) begin
      if (!nrst) begin
         fetch_st_reg <= F_IDLE;
         fetch_addr_reg <= 15'h0000;
         car_word_reg <= 16'h0000;
         sb_word_reg <= 16'h0000;
         proc_rdata <= 16'h0000;
         ram_addr <= 15'h0000;
         ram_dq_out <= 16'h0000;
         ram_dq_oe <= 1'b0;
         carrier_wave_ram_cs_n <= 1'b1;
         sideband_wave_ram_cs_n <= 1'b1;
         ram_we_n <= 1'b1;
         ram_oe_n <= 1'b1;
      end else if (!ctrl_cycle_reg) begin
         // Pass-through, registered one cycle to keep pins glitch-free.
         fetch_st_reg <= F_IDLE;
         fetch_addr_reg <= 15'h0000;
         ram_addr <= proc_addr;
         ram_dq_out <= proc_wdata;
         ram_dq_oe <= proc_wr & (proc_car_sel | proc_sb_sel);
         carrier_wave_ram_cs_n <= ~proc_car_sel;
         sideband_wave_ram_cs_n <= ~proc_sb_sel;
         ram_we_n <= ~proc_wr;
         ram_oe_n <= ~proc_rd;
         proc_rdata <= ram_dq_in;
      end else if (resync) begin
         fetch_st_reg <= F_IDLE;
         fetch_addr_reg <= 15'h0000;
         carrier_wave_ram_cs_n <= 1'b1;
         sideband_wave_ram_cs_n <= 1'b1;
         ram_oe_n <= 1'b1;
      end else begin
         ram_dq_oe <= 1'b0;
         ram_we_n <= 1'b1;
         case (fetch_st_reg)
            F_IDLE: begin
               carrier_wave_ram_cs_n <= 1'b1;
               sideband_wave_ram_cs_n <= 1'b1;
               ram_oe_n <= 1'b1;
               if (fifo_in_ready) begin
                  ram_addr <= car_addr;
                  carrier_wave_ram_cs_n <= 1'b0;
                  ram_oe_n <= 1'b0;
                  fetch_st_reg <= F_CAR;
               end
            end
            F_CAR: begin
               car_word_reg <= ram_dq_in;
               ram_addr <= fetch_addr_reg;
               carrier_wave_ram_cs_n <= 1'b1;
               sideband_wave_ram_cs_n <= 1'b0;
               fetch_st_reg <= F_SB;
            end
            F_SB: begin
               sb_word_reg <= ram_dq_in;
               sideband_wave_ram_cs_n <= 1'b1;
               ram_oe_n <= 1'b1;
               fetch_st_reg <= F_PUSH;
            end
            default: begin
               fetch_addr_reg <= fetch_addr_reg + 1'b1;
               fetch_st_reg <= F_IDLE;
            end
         endcase
      end
   end

   // Drain: on each tick the next word goes to the DACs; the strobe opens
   // a cycle after the data and closes a cycle before they may change.
   always @(posedge sys_clk) begin
      if (!nrst || flush) begin
         drain_st_reg <= D_IDLE;
         play_cnt_reg <= 15'h0000;
         carrier_dac_write_n <= 1'b1;
         sideband_dac_write_n <= 1'b1;
         sideband_dac_select <= 1'b0;
         if (!nrst) begin
            carrier_dac_data <= 16'h0000;
            sb13_dac_data <= 8'h00;
            sb24_dac_data <= 8'h00;
         end
      end else begin
         if (tick_reg) begin
            play_cnt_reg <= play_cnt_reg + 1'b1;
         end
         case (drain_st_reg)
            D_IDLE: begin
               if (fifo_pop) begin
                  carrier_dac_data <= fifo_out_data[31:16];
                  sb13_dac_data <= fifo_out_data[7:0];
                  sb24_dac_data <= fifo_out_data[15:8];
                  drain_st_reg <= D_LOW;
               end
            end
            D_LOW: begin
               carrier_dac_write_n <= 1'b0;
               sideband_dac_write_n <= 1'b0;
               sideband_dac_select <= 1'b1;
               drain_st_reg <= D_HIGH;
            end
            D_HIGH: begin
               carrier_dac_write_n <= 1'b1;
               sideband_dac_write_n <= 1'b1;
               sideband_dac_select <= 1'b0;
               drain_st_reg <= D_IDLE;
            end
            default: drain_st_reg <= D_IDLE;
         endcase
      end
   end

   // Bi-phase, sync and multiplexer outputs, all registered.
   always @(posedge sys_clk) begin
      if (!nrst) begin
         sine_biphase_out <= 1'b0;
         cosine_biphase_out <= 1'b0;
         sync_observe <= 1'b0;
         mux_select <= 4'h0;
         mux_a_output_enable <= 1'b0;
         mux_b_output_enable <= 1'b0;
      end else begin
         sine_biphase_out <= ctrl_cycle_reg & phase_prod[AW-1];
         cosine_biphase_out <= ctrl_cycle_reg & (phase_prod[AW-1] ^ phase_prod[AW-2]);
         sync_observe <= ctrl_cycle_reg & (sector_prod[AW+2:AW] == 3'h5);
         mux_select <= mux_reg[3:0];
         mux_a_output_enable <= mux_reg[`AUD_MUX_EN_A_BIT];
         // Only one multiplexer may feed the converter; A wins a tie.
         mux_b_output_enable <= mux_reg[`AUD_MUX_EN_B_BIT] & ~mux_reg[`AUD_MUX_EN_A_BIT];
      end
   end

   // One commutator line per sector of the sweep.
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_comm
         always @(posedge sys_clk) begin
            if (!nrst) begin
               commutator_ctrl[gi] <= 1'b0;
            end else begin
               // Held low off the antenna so the line drivers stay quiet.
               commutator_ctrl[gi] <= ctrl_cycle_reg & ~inactive_s
                                      & (sector_prod[AW+2:AW] == gi);
            end
         end
      end
   endgenerate
endmodule

// ===== test/aud_seq_asserts.sv
/*
 * Port checker for the playback sequencer, bound to its top module.
 * Assumes one clock, a synchronous active-low reset and the register map
 * of the shared defines header.
 */
`timescale 1ns/1ps
`include "aud_defines.vh"
module aud_seq_asserts #(
   parameter AW = 15
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic [AW-1:0] proc_addr,
   input wire logic proc_car_sel,
   input wire logic proc_sb_sel,
   input wire logic proc_wr,
   input wire logic [AW-1:0] ram_addr,
   input wire logic carrier_wave_ram_cs_n,
   input wire logic ram_we_n,
   input wire logic [15:0] carrier_dac_data,
   input wire logic [7:0] sb13_dac_data,
   input wire logic carrier_dac_write_n,
   input wire logic sideband_dac_write_n,
   input wire logic sideband_dac_select,
   input wire logic antenna_inactive,
   input wire logic [5:0] commutator_ctrl,
   input wire logic sync_observe,
   input wire logic mux_a_output_enable,
   input wire logic mux_b_output_enable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic cyc_reg; // Shadow of the cycle enable bit.
   logic seen_reg; // A strobe was seen since cycling began.
   logic [7:0] gap_reg; // Cycles since the last carrier strobe, saturating.
   // Helper state; the gap saturates so long empty spells never wrap small.
   always @(posedge sys_clk) begin
      if (!nrst) begin
         cyc_reg <= 1'b0;
         seen_reg <= 1'b0;
         gap_reg <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == `AUD_CTRL_OFS) cyc_reg <= reg_wdata[0];
         seen_reg <= cyc_reg && (seen_reg || !carrier_dac_write_n);
         gap_reg <= carrier_dac_write_n ? gap_reg + {7'h00, gap_reg != 8'hff} : 8'h00;
      end
   end
   property p_rst;
      $rose(nrst) |-> carrier_dac_write_n && ram_we_n && commutator_ctrl == 6'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle after reset");
   property p_pass;
      !cyc_reg && !reg_wr && proc_wr && proc_car_sel && !proc_sb_sel
         |=> !carrier_wave_ram_cs_n && !ram_we_n && ram_addr == $past(proc_addr);
   endproperty
   a_pass: assert property (p_pass) else $error("processor write not passed");
   property p_cyc;
      cyc_reg [*3] |-> ram_we_n;
   endproperty
   a_cyc: assert property (p_cyc) else $error("RAM written while cycling");
   property p_pair;
      !carrier_dac_write_n |-> !sideband_dac_write_n && sideband_dac_select;
   endproperty
   a_pair: assert property (p_pair) else $error("DAC strobes not paired");
   property p_one;
      !carrier_dac_write_n |=> carrier_dac_write_n
         && $stable(carrier_dac_data) && $stable(sb13_dac_data);
   endproperty
   a_one: assert property (p_one) else $error("strobe or data not stable");
   property p_gap;
      seen_reg && !carrier_dac_write_n |-> gap_reg >= 8'h13;
   endproperty
   a_gap: assert property (p_gap) else $error("word ticks too close");
   property p_idle;
      (!cyc_reg) [*3] |-> commutator_ctrl == 6'h00 && !sync_observe;
   endproperty
   a_idle: assert property (p_idle) else $error("commutator busy while idle");
   property p_ant;
      antenna_inactive [*4] |-> commutator_ctrl == 6'h00;
   endproperty
   a_ant: assert property (p_ant) else $error("commutator driven off antenna");
   property p_obs;
      (!antenna_inactive) [*4] |-> sync_observe == commutator_ctrl[5];
   endproperty
   a_obs: assert property (p_obs) else $error("sync output not last line");
   property p_hot;
      $onehot0(commutator_ctrl);
   endproperty
   a_hot: assert property (p_hot) else $error("two commutator lines high");
   property p_mux;
      !(mux_a_output_enable && mux_b_output_enable);
   endproperty
   a_mux: assert property (p_mux) else $error("both multiplexers enabled");
   c_strobe: cover property (!carrier_dac_write_n);
   c_comm: cover property (commutator_ctrl != 6'h00);
   c_mux_b: cover property (mux_b_output_enable);
endmodule
bind aud_seq aud_seq_asserts #(.AW(AW)) aud_seq_asserts_i (.sys_clk, .nrst, .reg_addr,
   .reg_wdata, .reg_wr, .proc_addr, .proc_car_sel, .proc_sb_sel, .proc_wr, .ram_addr,
   .carrier_wave_ram_cs_n, .ram_we_n, .carrier_dac_data, .sb13_dac_data,
   .carrier_dac_write_n, .sideband_dac_write_n, .sideband_dac_select, .antenna_inactive,
   .commutator_ctrl, .sync_observe, .mux_a_output_enable, .mux_b_output_enable);

// ===== test/aud_ram_model.sv
/*
 * Model of the carrier and sideband waveform RAMs on the sequencer's far side.
 * Assumes registered RAM pins in the sys_clk domain and asynchronous reads.
 */
`timescale 1ns/1ps
module aud_ram_model (
   input wire logic sys_clk,
   input wire logic [14:0] ram_addr,
   input wire logic [15:0] ram_dq_out,
   input wire logic ram_dq_oe,
   input wire logic carrier_wave_ram_cs_n,
   input wire logic sideband_wave_ram_cs_n,
   input wire logic ram_we_n,
   input wire logic ram_oe_n,
   output logic [15:0] ram_dq_in
);
   logic [15:0] car_mem [0:32767]; // Carrier words.
   logic [15:0] sb_mem [0:32767]; // Sideband words.
   logic [15:0] last_dq_reg; // Last bus value, inverted once released.
   logic rd_en; // Read cycle in progress.
   // Each word holds its own address so playback order can be checked.
   initial begin
      last_dq_reg = 16'h0000;
      for (int i = 0; i < 32768; i++) begin
         car_mem[i] = {1'b0, i[14:0]};
         sb_mem[i] = {1'b1, i[14:0]};
      end
   end
   assign rd_en = !ram_oe_n && ram_we_n;
   // A released bus must not keep the old word, or stale reads would pass.
   always_comb begin
      if (rd_en && !carrier_wave_ram_cs_n) ram_dq_in = car_mem[ram_addr];
      else if (rd_en && !sideband_wave_ram_cs_n) ram_dq_in = sb_mem[ram_addr];
      else ram_dq_in = ~last_dq_reg;
   end
   // Writes land at the edge while selected, write-enabled and driven.
   always @(posedge sys_clk) begin
      last_dq_reg <= ram_dq_in;
      if (!ram_we_n && ram_dq_oe && !carrier_wave_ram_cs_n) car_mem[ram_addr] <= ram_dq_out;
      if (!ram_we_n && ram_dq_oe && !sideband_wave_ram_cs_n) sb_mem[ram_addr] <= ram_dq_out;
   end
endmodule

// ===== test/test_aud_seq.sv
/*
 * Self-checking bench for the playback sequencer and its RAM model.
 * Assumes a 20 MHz clock and the register map of the defines header.
 */
`timescale 1ns/1ps
`include "aud_defines.vh"
module test_aud_seq;
   logic sys_clk, nrst, reg_wr, reg_rd, proc_car_sel, proc_sb_sel, proc_wr, proc_rd;
   logic [3:0] reg_addr, mux_select;
   logic [31:0] reg_wdata, reg_rdata, rd, c0;
   logic [14:0] proc_addr, ram_addr;
   logic [15:0] proc_wdata, proc_rdata, ram_dq_in, ram_dq_out, carrier_dac_data;
   logic ram_dq_oe, carrier_wave_ram_cs_n, sideband_wave_ram_cs_n, ram_we_n, ram_oe_n;
   logic [7:0] sb13_dac_data, sb24_dac_data;
   logic carrier_dac_write_n, sideband_dac_write_n, sideband_dac_select, offset_jumper;
   logic ground_check_pos, ground_check_neg, antenna_inactive, cycle_sync_in, doppler_config;
   logic sine_biphase_out, cosine_biphase_out, sync_observe;
   logic mux_a_output_enable, mux_b_output_enable;
   logic [5:0] commutator_ctrl;
   logic [5:0] mux_v [3] = '{6'h1f, 6'h25, 6'h3a}; // Written mux values.
   logic [5:0] mux_e [3] = '{6'h3e, 6'h15, 6'h2a}; // Select, enable A, enable B.
   logic [17:0] gc_v [3] = '{18'h08000, 18'h302ab, 18'h38000}; // Straps, offset.
   int n_mismatch, comparisons, cyc_cnt, k, tg, tc;
   logic sin_prev, cos_prev; // Bi-phase levels one cycle back, for toggle counting.
   aud_seq aud_seq_i (.*);
   aud_ram_model aud_ram_model_i (.*);
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task check_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task check_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask
   task end_of_test;
      $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe.
   task reg_read(input logic [3:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   // Holds the request two edges: pins follow one edge late, read data one more.
   task proc_cycle(input logic wr, input logic car, input logic [14:0] a,
                   input logic [15:0] d);
      @(posedge sys_clk);
      proc_addr <= a;
      proc_wdata <= d;
      proc_car_sel <= car;
      proc_sb_sel <= !car;
      proc_wr <= wr;
      proc_rd <= !wr;
      repeat (2) @(posedge sys_clk);
      {proc_wr, proc_rd, proc_car_sel, proc_sb_sel} <= 4'h0;
      #1 rd = {16'h0000, proc_rdata};
   endtask
   // Waits for a carrier strobe and checks the word pair it carries.
   task strobe_check(input logic [14:0] off);
      for (k = 0; k < 100 && carrier_dac_write_n !== 1'b0; k++) @(posedge sys_clk) #1;
      check_bit(carrier_dac_write_n, 1'b0);
      check_bit(sideband_dac_write_n, 1'b0);
      check_bit(sideband_dac_select, 1'b1);
      check_bit(sb24_dac_data[7], 1'b1);
      check_word(carrier_dac_data[14:0] - {sb24_dac_data[6:0], sb13_dac_data}, off);
   endtask
   // A hang is cut short well past the expected run length.
   always @(posedge sys_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 90000) begin
         n_mismatch++;
         end_of_test;
      end
   end
   initial begin
      {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, proc_wr, proc_rd} = '0;
      {proc_addr, proc_wdata, proc_car_sel, proc_sb_sel, offset_jumper} = '0;
      {ground_check_pos, ground_check_neg, antenna_inactive, cycle_sync_in} = 4'h2;
      doppler_config = 1'b1;
      {n_mismatch, comparisons, cyc_cnt} = '0;
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1; // Released once here, so no further reset comes.
      reg_read(`AUD_CTRL_OFS);
      check_word(rd, 32'h0);
      reg_read(4'hc);
      check_word(rd, 32'h0);
      $display("test reset done");
      proc_cycle(1'b1, 1'b1, 15'h7fff, 16'h1234);
      proc_cycle(1'b1, 1'b0, 15'h7fff, 16'habcd);
      proc_cycle(1'b0, 1'b1, 15'h7fff, 16'h0000);
      check_word(rd, 32'h1234);
      proc_cycle(1'b0, 1'b0, 15'h7fff, 16'h0000);
      check_word(rd, 32'habcd);
      $display("test pass_through done");
      for (int m = 0; m < 3; m++) begin
         reg_write(`AUD_MUX_OFS, {26'h0, mux_v[m]});
         repeat (2) @(posedge sys_clk) #1;
         check_word({mux_select, mux_a_output_enable, mux_b_output_enable}, mux_e[m]);
         reg_read(`AUD_MUX_OFS);
         check_word(rd, {26'h0, mux_v[m]});
      end
      $display("test mux done");
      reg_write(`AUD_CTRL_OFS, 32'h1);
      proc_cycle(1'b1, 1'b1, 15'h0000, 16'hffff);
      repeat (200) @(posedge sys_clk);
      reg_read(`AUD_STAT_OFS);
      check_bit(rd[0], 1'b1);
      check_bit(rd[2], 1'b1);
      c0 = rd;
      repeat (2033) @(posedge sys_clk);
      reg_read(`AUD_STAT_OFS);
      check_bit((rd[30:16] - c0[30:16]) inside {15'h64, 15'h65}, 1'b1);
      $display("test rate done");
      @(posedge sys_clk) cycle_sync_in <= 1'b1;
      repeat (6) @(posedge sys_clk);
      reg_read(`AUD_STAT_OFS);
      check_bit(rd[30:16] < 15'h2, 1'b1);
      cycle_sync_in <= 1'b0;
      antenna_inactive <= 1'b0;
      repeat (6) @(posedge sys_clk) #1;
      check_word(commutator_ctrl, 6'h01);
      check_bit(sync_observe, 1'b0);
      antenna_inactive <= 1'b1;
      repeat (6) @(posedge sys_clk) #1;
      check_word(commutator_ctrl, 6'h00);
      $display("test resync done");
      for (int g = 0; g < 3; g++) begin
         {offset_jumper, ground_check_pos, ground_check_neg} <= gc_v[g][17:15];
         repeat (600) @(posedge sys_clk) #1;
         strobe_check(gc_v[g][14:0]);
      end
      $display("test playback done");
      for (int d = 1; d >= 0; d--) begin
         doppler_config <= d[0];
         repeat (10) @(posedge sys_clk) #1;
         tg = 0;
         tc = 0;
         sin_prev = sine_biphase_out;
         cos_prev = cosine_biphase_out;
         // Count level changes of both outputs over about 740 word ticks.
         repeat (15000) begin
            @(posedge sys_clk) #1;
            if (sine_biphase_out != sin_prev) tg++;
            if (cosine_biphase_out != cos_prev) tc++;
            sin_prev = sine_biphase_out;
            cos_prev = cosine_biphase_out;
         end
         check_bit((tg > 0) == d[0], 1'b1);
         check_bit((tc > 0) == d[0], 1'b1);
      end
      $display("test biphase done");
      reg_write(`AUD_CTRL_OFS, 32'h0);
      repeat (4) @(posedge sys_clk);
      reg_read(`AUD_STAT_OFS);
      check_bit(rd[0], 1'b0);
      check_bit(rd[2], 1'b0);
      $display("test stop done");
      end_of_test;
   end
endmodule
